// *** sbf_port.sv ***
// Notes on behaviour
// - all-zero baud fields divide clock by two
// - divisor is (preselect+1) times 2^(select+1)
// - divider runs only for active master transfers
// - automatic select low during transfer, high idle
// - automatic select needs master, output and fault enables
// - automatic select output suppresses fault detection
// - single-wire uses MOSI for master, MISO slave
// - shared pin direction follows drive enable bit
// - clock out as master, in as slave
// - master with detection sets fault on select low
// - no fault without detection or in slave mode
// - fault forces slave, drivers off, transfer aborted
// - single-wire master fault drops shared pin enable
// - status read then control write clears fault
// - disabled block idles, registers still accessible
// - wait without halt keeps normal operation
// - halted wait freezes master transfer, then resumes
// - halted slave keeps shifting its current source
// - slave completion deferred until wait is left
// - idle wait cycle gives no completion
// - stopped clock freezes master and slave alike, slave misses edges
// - received data reads zero after reset
// - fault clears the master select bit
// - interrupt is enabled OR of three flags
// - byte dropped while done flag still set
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////
module sbf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // module clock
	input wire logic rst_n, // async reset
	input wire logic en, // clock enable
	input wire logic in_valid, // write request
	output logic in_ready, // room left
	input wire logic [WIDTH-1:0] in_data, // write word
	output logic out_valid, // word waiting
	input wire logic out_ready, // reader takes word
	output logic [WIDTH-1:0] out_data // oldest word
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wp_reg;
	logic [PW-1:0] rp_reg;
	logic [PW:0] cnt_reg;
	logic push;
	logic pop;
	logic [PW-1:0] last;

	assign last = PW'(DEPTH - 1);
	assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rp_reg];

	always_ff @(posedge clk) begin
		if (en && push) begin
			mem[wp_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else if (en) begin
			if (push) begin
				wp_reg <= (wp_reg == last) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == last) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

////////////////////////////////////////////////////////////////
module sbf_port
	import sbf_pkg::*;
#(
	parameter int FIFO_DEPTH = SBF_FIFO_DEPTH
) (
	input wire logic SYS_CLK, // module clock
	input wire logic RST_N, // async reset, low active
	input wire logic CLK_EN, // freezes all state when low
	input wire sbf_cfg_t CFG, // control fields
	input wire logic WAIT_MODE, // processor in wait
	input wire logic CR1_WR, // first control register write
	input wire logic CR1_MASTER, // master select bit written
	input wire logic STATUS_RD, // status register read
	input wire logic DONE_CLR, // clears transfer done flag
	input wire logic TX_VALID, // transmit byte offered
	output logic TX_READY, // transmit fifo has room
	input wire logic [7:0] TX_DATA, // transmit byte
	input wire sbf_pin_in_t PIN_IN, // raw pin levels
	output sbf_pin_out_t PIN_OUT, // pin drive and enables
	output logic MASTER_SELECT, // master select bit
	output logic MODE_FAULT_FLAG, // mode fault flag
	output logic TRANSFER_DONE_FLAG, // transfer done flag
	output logic TRANSMIT_EMPTY_FLAG, // holding register empty
	output logic [7:0] RX_DATA, // received byte
	output logic IRQ // interrupt request
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers: a change counts once stage 2 and 3 agree
	logic [3:0] s1_reg;
	logic [3:0] s2_reg;
	logic [3:0] s3_reg;
	logic [3:0] filt_reg;
	logic [3:0] filt_next;
	logic sck_d_reg;
	logic ss_d_reg;

	assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_reg <= SBF_PIN_RST;
			s2_reg <= SBF_PIN_RST;
			s3_reg <= SBF_PIN_RST;
			filt_reg <= SBF_PIN_RST;
			sck_d_reg <= 1'b0;
			ss_d_reg <= 1'b1;
		end else if (CLK_EN) begin
			s1_reg <= PIN_IN;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			filt_reg <= filt_next;
			sck_d_reg <= filt_reg[3];
			ss_d_reg <= filt_reg[2];
		end
	end

	wire sck_f = filt_reg[3];
	wire ss_n_f = filt_reg[2];
	wire mosi_f = filt_reg[1];
	wire miso_f = filt_reg[0];

	////////////////////////////////////////////////////////////////
	// mode decode
	logic master_reg;
	logic fault_reg;
	logic arm_reg;
	sbf_state_t st_reg;
	logic tx_full_reg;
	logic [7:0] tx_hold_reg;

	wire en = CFG.block_enable;
	wire halted = WAIT_MODE & CFG.halt_in_wait;
	wire sw = CFG.single_wire_data_mode;
	wire is_master = en & master_reg & ~fault_reg;
	wire slave_act = en & ~master_reg & ~fault_reg;
	wire selected = ~ss_n_f;
	wire auto_ss = is_master & CFG.select_output_enable & CFG.fault_detect_enable;
	// select output takes the pin, so the fault watcher must be off
	wire fault_det = is_master & CFG.fault_detect_enable
		& ~CFG.select_output_enable & ~ss_n_f;

	////////////////////////////////////////////////////////////////
	// transmit path: fifo feeds the holding register
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic tx_load;
	logic m_start;
	logic s_load;
	logic s_consume;

	sbf_fifo #(
		.WIDTH(SBF_DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.en(CLK_EN),
		.in_valid(TX_VALID),
		.in_ready(TX_READY),
		.in_data(TX_DATA),
		.out_valid(fifo_valid),
		.out_ready(~tx_full_reg),
		.out_data(fifo_data)
	);

	assign tx_load = fifo_valid & ~tx_full_reg;
	wire ss_fall = slave_act & ss_d_reg & ~ss_n_f;
	assign s_load = ss_fall & tx_full_reg;
	// in halted wait the slave keeps resending the same held byte
	assign s_consume = s_load & ~halted;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_full_reg <= 1'b0;
			tx_hold_reg <= SBF_DATA_RST;
		end else if (CLK_EN) begin
			if (tx_load) begin
				tx_full_reg <= 1'b1;
				tx_hold_reg <= fifo_data;
			end else if (m_start || s_consume) begin
				tx_full_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// baud divider
	logic [SBF_DIV_W-1:0] div_cnt_reg;
	logic [SBF_DIV_W-1:0] half_len;
	logic div_run;
	logic tick;

	// half period is (preselect+1) * 2^select, so a full period doubles it
	assign half_len = SBF_DIV_W'({1'b0, CFG.baud_preselect} + SBF_ONE4)
		<< CFG.baud_select;
	assign div_run = (st_reg == SBF_RUN) & is_master & ~halted;
	assign tick = div_run & (div_cnt_reg == half_len - 1'b1);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			div_cnt_reg <= '0;
		end else if (CLK_EN) begin
			if (st_reg != SBF_RUN || !is_master) begin
				div_cnt_reg <= '0;
			end else if (div_run) begin
				div_cnt_reg <= tick ? '0 : div_cnt_reg + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// master sequencer: 16 clock edges, then one more half period
	logic [4:0] edge_reg;
	logic sck_reg;
	logic m_comp;

	assign m_start = (st_reg == SBF_IDLE) & is_master & tx_full_reg & ~halted;
	assign m_comp = tick & (edge_reg == SBF_EDGES);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_reg <= SBF_IDLE;
			edge_reg <= '0;
			sck_reg <= 1'b0;
		end else if (CLK_EN) begin
			// a fault in the start cycle must not let the transfer begin
			if (!is_master || fault_det) begin
				st_reg <= SBF_IDLE;
				sck_reg <= 1'b0;
			end else if (m_start) begin
				st_reg <= SBF_RUN;
				edge_reg <= '0;
				sck_reg <= 1'b0;
			end else if (m_comp) begin
				st_reg <= SBF_IDLE;
			end else if (tick) begin
				edge_reg <= edge_reg + 1'b1;
				sck_reg <= ~sck_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// shift register shared by master and slave
	logic [7:0] sh_reg;
	logic samp_reg;
	logic [2:0] bit_reg;
	logic din_m;
	logic din_s;
	logic s_rise;
	logic s_fall;
	logic s_comp;
	logic m_samp;
	logic m_shift;

	assign din_m = sw ? mosi_f : miso_f;
	assign din_s = sw ? miso_f : mosi_f;
	assign s_rise = slave_act & selected & sck_f & ~sck_d_reg;
	assign s_fall = slave_act & selected & ~sck_f & sck_d_reg;
	// the slave shifts on its own edges even in halted wait
	assign s_comp = s_fall & (bit_reg == SBF_LAST_BIT);
	assign m_samp = tick & ~m_comp & ~edge_reg[0];
	assign m_shift = tick & ~m_comp & edge_reg[0];

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sh_reg <= SBF_DATA_RST;
			samp_reg <= 1'b0;
			bit_reg <= '0;
		end else if (CLK_EN) begin
			if (m_start) begin
				sh_reg <= tx_hold_reg;
			end else if (ss_fall) begin
				bit_reg <= '0;
				// without a new byte the last received byte goes back out
				if (s_load) begin
					sh_reg <= tx_hold_reg;
				end
			end else if (m_shift) begin
				sh_reg <= {sh_reg[6:0], 1'b0};
			end else if (s_rise) begin
				samp_reg <= din_s;
			end else if (s_fall) begin
				sh_reg <= {sh_reg[6:0], samp_reg};
				bit_reg <= bit_reg + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// master receive: returning data reaches the logic four cycles late
	// through the pin synchroniser, so each bit is taken that much after
	// its rising edge; this keeps the fastest divisor usable
	logic [3:0] samp_dly_reg;
	logic [7:0] m_rx_reg;
	logic [2:0] m_bit_reg;
	logic m_got;
	logic m_done;

	assign m_got = samp_dly_reg[3];
	assign m_done = m_got & (m_bit_reg == SBF_LAST_BIT);

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			samp_dly_reg <= '0;
			m_rx_reg <= SBF_DATA_RST;
			m_bit_reg <= '0;
		end else if (CLK_EN) begin
			if (!is_master) begin
				samp_dly_reg <= '0;
				m_bit_reg <= '0;
			end else begin
				samp_dly_reg <= {samp_dly_reg[2:0], m_samp};
				if (m_got) begin
					m_rx_reg <= {m_rx_reg[6:0], din_m};
					m_bit_reg <= m_bit_reg + 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// completion, deferral through halted wait, receive register
	logic pend_reg;
	logic [7:0] pend_byte_reg;
	logic [7:0] comp_byte;
	logic defer;
	logic deliver;
	logic [7:0] deliver_byte;
	logic done_reg;
	logic [7:0] rx_reg;

	assign comp_byte = m_done ? {m_rx_reg[6:0], din_m} : {sh_reg[6:0], samp_reg};
	assign defer = s_comp & halted;
	// only a byte finished in wait is pending, so idle waits give nothing
	assign deliver = ((m_done | s_comp) & ~defer) | (pend_reg & ~halted);
	assign deliver_byte = pend_reg ? pend_byte_reg : comp_byte;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend_reg <= 1'b0;
			pend_byte_reg <= SBF_DATA_RST;
		end else if (CLK_EN) begin
			if (defer) begin
				pend_reg <= 1'b1;
				pend_byte_reg <= comp_byte;
			end else if (!halted) begin
				pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			done_reg <= 1'b0;
			rx_reg <= SBF_DATA_RST;
		end else if (CLK_EN) begin
			// set wins over a clear in the same cycle
			done_reg <= deliver | (done_reg & ~DONE_CLR);
			if (deliver && !done_reg) begin
				rx_reg <= deliver_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// mode fault flag and master select bit
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			fault_reg <= 1'b0;
			arm_reg <= 1'b0;
			master_reg <= 1'b0;
		end else if (CLK_EN) begin
			fault_reg <= fault_det | (fault_reg & ~(arm_reg & CR1_WR));
			if (fault_det || (arm_reg && CR1_WR)) begin
				arm_reg <= 1'b0;
			end else if (STATUS_RD && fault_reg) begin
				arm_reg <= 1'b1;
			end
			if (fault_det) begin
				master_reg <= 1'b0;
			end else if (CR1_WR) begin
				master_reg <= CR1_MASTER;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// pins; a fault leaves every driver off until it is cleared
	wire drv_ok = ~sw | CFG.shared_pin_drive_enable;

	assign PIN_OUT.sck_o = sck_reg;
	assign PIN_OUT.sck_oe = is_master;
	assign PIN_OUT.mosi_o = sh_reg[7];
	assign PIN_OUT.mosi_oe = is_master & drv_ok;
	assign PIN_OUT.miso_o = sh_reg[7];
	assign PIN_OUT.miso_oe = slave_act & selected & drv_ok;
	assign PIN_OUT.ss_n_o = (st_reg != SBF_RUN);
	assign PIN_OUT.ss_n_oe = auto_ss;

	assign MASTER_SELECT = master_reg;
	assign MODE_FAULT_FLAG = fault_reg;
	assign TRANSFER_DONE_FLAG = done_reg;
	assign TRANSMIT_EMPTY_FLAG = ~tx_full_reg;
	assign RX_DATA = rx_reg;
	assign IRQ = en & (fault_reg | done_reg | ~tx_full_reg);

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	property p_div_two;
		(CLK_EN && div_run && !m_comp && half_len == 11'h001 && !CFG.baud_preselect[0])
			|-> tick;
	endproperty
	a_div_two: assert property (p_div_two) else $error("divide by two missed");

	property p_div_span;
		(st_reg == SBF_RUN && is_master) |-> (div_cnt_reg < half_len);
	endproperty
	a_div_span: assert property (p_div_span) else $error("divider over half period");

	property p_div_idle;
		(CLK_EN && st_reg == SBF_IDLE) |=> (div_cnt_reg == '0);
	endproperty
	a_div_idle: assert property (p_div_idle) else $error("divider runs while idle");

	property p_auto_ss;
		auto_ss |-> (PIN_OUT.ss_n_o == (st_reg == SBF_IDLE));
	endproperty
	a_auto_ss: assert property (p_auto_ss) else $error("select output wrong");

	property p_fault_cause;
		(CLK_EN && $rose(fault_reg)) |-> $past(master_reg)
			&& !$past(CFG.select_output_enable) && !$past(ss_n_f);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault without cause");

	property p_fault_off;
		fault_reg |-> !(PIN_OUT.sck_oe | PIN_OUT.mosi_oe | PIN_OUT.miso_oe | PIN_OUT.ss_n_oe);
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("driver on under fault");

	property p_fault_master;
		(CLK_EN && fault_det) |=> !master_reg && fault_reg && st_reg == SBF_IDLE;
	endproperty
	a_fault_master: assert property (p_fault_master) else $error("master kept on fault");

	property p_overrun;
		(CLK_EN && done_reg && deliver) |=> $stable(rx_reg);
	endproperty
	a_overrun: assert property (p_overrun) else $error("data overwritten");

	property p_defer;
		(CLK_EN && defer && !done_reg) |=> !done_reg ##0 pend_reg;
	endproperty
	a_defer: assert property (p_defer) else $error("completion not deferred");

	property p_freeze;
		(CLK_EN && halted && st_reg == SBF_RUN && is_master) |=> $stable(div_cnt_reg)
			&& $stable(sck_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("master not frozen");

	property p_irq_off;
		!en |-> !IRQ;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

	c_master_done: cover property (CLK_EN && m_comp);
	c_slave_done: cover property (CLK_EN && s_comp && !halted);
	c_fault: cover property (CLK_EN && fault_det);
	c_deferred: cover property (CLK_EN && pend_reg && !halted);
endmodule
`default_nettype wire

// *** sbf_pkg.sv ***
`default_nettype none
package sbf_pkg;
	localparam int SBF_DATA_W = 8;
	localparam int SBF_FIFO_DEPTH = 8;
	localparam int SBF_DIV_W = 11;
	localparam logic [4:0] SBF_EDGES = 5'h10;
	localparam logic [2:0] SBF_LAST_BIT = 3'h7;
	localparam logic [7:0] SBF_DATA_RST = 8'h00;
	// pin input order: sck, ss_n, mosi, miso
	localparam logic [3:0] SBF_PIN_RST = 4'h4;
	localparam logic [3:0] SBF_ONE4 = 4'h1;

	typedef enum logic [1:0] {
		SBF_IDLE = 2'b00,
		SBF_RUN = 2'b01
	} sbf_state_t;

	typedef struct packed {
		logic [2:0] baud_preselect;
		logic [2:0] baud_select;
		logic select_output_enable;
		logic fault_detect_enable;
		logic single_wire_data_mode;
		logic shared_pin_drive_enable;
		logic block_enable;
		logic halt_in_wait;
	} sbf_cfg_t;

	typedef struct packed {
		logic sck;
		logic ss_n;
		logic mosi;
		logic miso;
	} sbf_pin_in_t;

	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic ss_n_o;
		logic ss_n_oe;
	} sbf_pin_out_t;
endpackage
`default_nettype wire

// *** sbf_slave_model.sv ***
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////
module sbf_slave_model (
	input wire logic sck, // serial clock from master
	input wire logic ss_n, // select, low active
	input wire logic mosi, // data from master
	output logic miso, // data to master
	input wire logic [7:0] tx_byte, // byte returned next frame
	output logic [7:0] rx_byte // last whole byte received
);
	logic [7:0] sh_reg;
	logic [2:0] cnt_reg;
	logic smp_reg;
	logic last_reg;

	initial begin
		sh_reg = 8'h00;
		cnt_reg = 3'h0;
		smp_reg = 1'b0;
		last_reg = 1'b0;
		rx_byte = 8'h00;
	end

	always @(negedge ss_n) begin
		sh_reg = tx_byte;
		cnt_reg = 3'h0;
	end

	always @(posedge ss_n) begin
		last_reg = sh_reg[7];
	end

	// mode 0 slave: latch on rise, shift on fall, msb first
	always @(posedge sck) begin
		if (!ss_n) smp_reg = mosi;
	end

	always @(negedge sck) begin
		if (!ss_n) begin
			sh_reg = {sh_reg[6:0], smp_reg};
			cnt_reg = cnt_reg + 3'h1;
			if (cnt_reg == 3'h0) rx_byte = sh_reg;
		end
	end

	// released line shows the inverse of the last bit, never a stale copy
	always @(*) begin
		miso = ss_n ? ~last_reg : sh_reg[7];
	end
endmodule
`default_nettype wire

// *** sbf_port_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end

////////////////////////////////////////////////////////////////
module sbf_port_tb_top;
	import sbf_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	sbf_cfg_t cfg = '0;
	logic wait_mode = 1'b0;
	logic cr1_wr = 1'b0;
	logic cr1_master = 1'b0;
	logic status_rd = 1'b0;
	logic done_clr = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_ready;
	logic [7:0] tx_data = 8'h00;
	logic ss_ext_n = 1'b1;
	logic m_sck = 1'b0;
	logic m_mosi = 1'b0;
	sbf_pin_in_t pin_in;
	sbf_pin_out_t pin_out;
	logic master_sel, mode_fault, done_flag, empty_flag, irq, slv_miso;
	logic [7:0] rx_data, slv_tx, slv_rx;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed = 32'h12be1b7a;

	always #5 clk = ~clk;

	// ss_n has a pull-up: the bench drives it high unless a rival master or the remote master selecting the slave is modelled
	// m_sck and m_mosi stand for a remote master when the port is a slave
	assign pin_in = {pin_out.sck_oe ? pin_out.sck_o : m_sck,
		pin_out.ss_n_oe ? pin_out.ss_n_o : ss_ext_n,
		pin_out.mosi_oe ? pin_out.mosi_o : m_mosi,
		pin_out.miso_oe ? pin_out.miso_o : slv_miso};

	sbf_port i_sbf_port (.SYS_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en), .CFG(cfg),
		.WAIT_MODE(wait_mode), .CR1_WR(cr1_wr), .CR1_MASTER(cr1_master),
		.STATUS_RD(status_rd), .DONE_CLR(done_clr), .TX_VALID(tx_valid),
		.TX_READY(tx_ready), .TX_DATA(tx_data), .PIN_IN(pin_in), .PIN_OUT(pin_out),
		.MASTER_SELECT(master_sel), .MODE_FAULT_FLAG(mode_fault),
		.TRANSFER_DONE_FLAG(done_flag), .TRANSMIT_EMPTY_FLAG(empty_flag),
		.RX_DATA(rx_data), .IRQ(irq));

	sbf_slave_model i_sbf_slave_model (.sck(pin_in.sck), .ss_n(pin_in.ss_n),
		.mosi(pin_in.mosi), .miso(slv_miso), .tx_byte(slv_tx), .rx_byte(slv_rx));

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish;
		end
	end

	function automatic int exp_div(input logic [2:0] pre, input logic [2:0] sel);
		exp_div = (int'(pre) + 1) * (2 << sel);
	endfunction

	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// 0 control write, 1 status read, 2 done clear
	task automatic strobe(input int w);
		cr1_wr = (w == 0);
		status_rd = (w == 1);
		done_clr = (w == 2);
		cyc_wait(1);
		cr1_wr = 1'b0;
		status_rd = 1'b0;
		done_clr = 1'b0;
	endtask

	// mode 0 plain, 1 halted wait mid-frame, 2 wait without halt, 3 overrun
	task automatic xfer(input logic [2:0] pre, input logic [2:0] sel, input logic [7:0] d,
			input logic [7:0] s, input int mode, input logic [7:0] exp_rx);
		int c, r1, r2, nr, bad, moved;
		logic ps, hs;
		r1 = 0;
		r2 = 0;
		nr = 0;
		bad = 0;
		ps = 1'b0;
		cfg.baud_preselect = pre;
		cfg.baud_select = sel;
		cfg.halt_in_wait = (mode == 1);
		wait_mode = (mode == 2);
		slv_tx = s;
		tx_data = d;
		tx_valid = 1'b1;
		cyc_wait(1);
		tx_valid = 1'b0;
		for (c = 0; c < 5000 && !(nr == 8 && pin_out.ss_n_o === 1'b1); c++) begin
			cyc_wait(1);
			if (pin_out.sck_o === 1'b1 && ps === 1'b0) begin
				nr++;
				if (nr == 1) r1 = c;
				if (nr == 2) r2 = c;
				if (pin_out.ss_n_o !== 1'b0 || pin_out.sck_oe !== 1'b1) bad++;
				if (nr == 5 && mode == 1) begin
					wait_mode = 1'b1;
					cyc_wait(2);
					hs = pin_out.sck_o;
					moved = 0;
					repeat (30) begin
						cyc_wait(1);
						if (pin_out.sck_o !== hs) moved++;
					end
					`CHK("frozen sck", 0, moved)
					wait_mode = 1'b0;
				end
			end
			ps = pin_out.sck_o;
		end
		cyc_wait(3);
		`CHK("sck period", exp_div(pre, sel), r2 - r1)
		`CHK("sck rises", 8, nr)
		`CHK("select during frame", 0, bad)
		`CHK("select idle", 1'b1, pin_out.ss_n_o)
		`CHK("done flag", 1'b1, done_flag)
		`CHK("rx data", exp_rx, rx_data)
		`CHK("slave rx", d, slv_rx)
		wait_mode = 1'b0;
		if (mode != 3) strobe(2);
	endtask

	// bench as master; half periods of 8 cycles outlast the pin synchroniser
	task automatic sxfer(input logic [7:0] d, input logic [7:0] h, input int wmode);
		logic [7:0] got;
		got = 8'h00;
		tx_data = h;
		tx_valid = 1'b1;
		cyc_wait(1);
		tx_valid = 1'b0;
		cyc_wait(3);
		ss_ext_n = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i == 3 && wmode == 1) begin
				cfg.halt_in_wait = 1'b1;
				wait_mode = 1'b1;
			end
			m_mosi = d[7 - i];
			cyc_wait(8);
			m_sck = 1'b1;
			got = {got[6:0], pin_in.miso};
			cyc_wait(8);
			m_sck = 1'b0;
		end
		cyc_wait(8);
		ss_ext_n = 1'b1;
		cyc_wait(8);
		if (wmode == 1) begin
			`CHK("done held in wait", 1'b0, done_flag)
			wait_mode = 1'b0;
			cyc_wait(2);
		end
		`CHK("slave sent", h, got)
		`CHK("slave done", 1'b1, done_flag)
		`CHK("slave rx byte", d, rx_data)
		strobe(2);
	endtask

	logic [2:0] tp[4] = '{3'h0, 3'h0, 3'h1, 3'h2};
	logic [2:0] ts[4] = '{3'h0, 3'h1, 3'h0, 3'h1};

	initial begin
		logic [7:0] d, s, keep;
		cfg.block_enable = 1'b1;
		cfg.select_output_enable = 1'b1;
		cfg.fault_detect_enable = 1'b1;
		slv_tx = 8'h00;
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		`CHK("rx after reset", 8'h00, rx_data)
		`CHK("irq after reset", 1'b1, irq)
		cr1_master = 1'b1;
		strobe(0);
		`CHK("master bit", 1'b1, master_sel)
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			d = 8'($random(seed));
			s = 8'($random(seed));
			if (i < 4) xfer(tp[i], ts[i], d, s, 0, s);
			else xfer(3'($random(seed) & 3), 3'($random(seed) & 3), d, s, i % 3, s);
		end
		$display("test baud and wait done");
		keep = 8'h3c;
		xfer(3'h0, 3'h1, 8'ha5, keep, 3, keep);
		xfer(3'h0, 3'h1, 8'h96, 8'hf0, 3, keep);
		strobe(2);
		$display("test overrun done");
		cfg.single_wire_data_mode = 1'b1;
		cfg.shared_pin_drive_enable = 1'b1;
		d = 8'($random(seed));
		xfer(3'h1, 3'h0, d, 8'h00, 0, d);
		cfg.shared_pin_drive_enable = 1'b0;
		cyc_wait(1);
		`CHK("shared pin released", 1'b0, pin_out.mosi_oe)
		cfg.single_wire_data_mode = 1'b0;
		$display("test single wire done");
		cfg.select_output_enable = 1'b0;
		cfg.fault_detect_enable = 1'b0;
		ss_ext_n = 1'b0;
		cyc_wait(10);
		`CHK("fault ignored", 1'b0, mode_fault)
		ss_ext_n = 1'b1;
		cfg.fault_detect_enable = 1'b1;
		cfg.baud_select = 3'h3;
		cyc_wait(5);
		tx_data = 8'hc3;
		tx_valid = 1'b1;
		cyc_wait(1);
		tx_valid = 1'b0;
		cyc_wait(20);
		ss_ext_n = 1'b0;
		cyc_wait(8);
		`CHK("fault set", 1'b1, mode_fault)
		`CHK("master cleared", 1'b0, master_sel)
		`CHK("drivers off", 3'h0, {pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe})
		`CHK("irq on fault", 1'b1, irq)
		ss_ext_n = 1'b1;
		cyc_wait(5);
		strobe(0);
		`CHK("fault kept", 1'b1, mode_fault)
		strobe(1);
		strobe(0);
		`CHK("fault cleared", 1'b0, mode_fault)
		`CHK("master back", 1'b1, master_sel)
		$display("test mode fault done");
		cr1_master = 1'b0;
		strobe(0);
		sxfer(8'($random(seed)), 8'hc6, 0);
		cfg.halt_in_wait = 1'b1;
		wait_mode = 1'b1;
		cyc_wait(5);
		wait_mode = 1'b0;
		cyc_wait(5);
		`CHK("idle wait", 1'b0, done_flag)
		sxfer(8'($random(seed)), 8'h81, 1);
		$display("test slave done");
		cfg.block_enable = 1'b0;
		cyc_wait(3);
		`CHK("irq disabled", 1'b0, irq)
		$display("test enable done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
